// ==== src/pcicsr_regs.sv ====
`include "pcicsr_regs.svh"
// Summary of operation
// - command bits 15-10 read zero, ignore writes
// - back-to-back enable bit 9 reads zero
// - bit 8 enables system-error driver, resets 0
// - address parity reports system error if 8,6
// - stepping bit 7 hardwired zero
// - bit 6 selects parity error response
// - bit 5 enables palette snooping, not claiming
// - write-invalidate bit 4 hardwired zero
// - special-cycle bit 3 zero, never responds
// - bit 2 allows bus initiator use
// - bit 1 allows memory cycle claiming
// - bit 0 allows I/O cycle claiming
// - command resets zero, writable 8,6,5,2,1,0
// - write one clears status, reads harmless
// - status resets 0210h, clearable 15-11,8
// - parity sets 15, signaled error sets 14
// - aborts set status bits 13, 12, 11
// - bit 8 set on master PERR, parity on
// - timing 01b, capability bit 4 reads one
module pcicsr_regs
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cfgWrite, // config write strobe, one cycle
	input wire logic [7:0] cfgAddr, // dword-aligned config byte address
	input wire logic [3:0] cfgByteEn, // byte lanes of the dword
	input wire logic [31:0] cfgWriteData, // write data
	output logic [31:0] cfgReadData, // command low, status high
	input wire pcicsr_pkg::pcicsr_events_t events, // engine error pulses
	output pcicsr_pkg::pcicsr_enables_t enables, // decoded enables
	output logic systemErrorAssert, // request engine to drive SERR
	output logic parityErrorAssert // request engine to drive PERR
);

	////////////////////////////////////////////////////////////////////
	// reset release
	logic resetSync1; // first stage, read only by second
	logic resetSync2; // synchronised reset, active low
	// async assert, clean release against clk
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			resetSync1 <= 1'b0;
			resetSync2 <= 1'b0;
		end
		else
		begin
			resetSync1 <= 1'b1;
			resetSync2 <= resetSync1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// storage
	logic [15:0] command; // only writable bits ever become set
	logic [15:0] statusFlags; // only clearable bits ever become set
	logic hitDword; // access targets the command/status dword
	logic [15:0] cmdWrMask; // byte-lane mask for the command half
	logic [15:0] stsWrMask; // byte-lane mask for the status half
	logic [15:0] stsSet; // hardware set requests
	logic [15:0] stsClr; // software clear requests

	// expand byte enables of one half-word into a bit mask
	function automatic logic [15:0] lanes(input logic [1:0] be);
		lanes = {{8{be[1]}}, {8{be[0]}}};
	endfunction : lanes

	assign hitDword = cfgWrite && (cfgAddr == `PCICSR_OFS_COMMAND);
	assign cmdWrMask = hitDword ? lanes(cfgByteEn[1:0]) : 16'h0000;
	assign stsWrMask = hitDword ? lanes(cfgByteEn[3:2]) : 16'h0000;

	////////////////////////////////////////////////////////////////////
	// command register
	// hardwired bits never load, so they read zero forever
	always_ff @(posedge clk or negedge resetSync2)
	begin
		if (!resetSync2)
			command <= `PCICSR_CMD_RESET;
		else
			command <= (command & ~(cmdWrMask & `PCICSR_CMD_WMASK)) |
				(cfgWriteData[15:0] & cmdWrMask & `PCICSR_CMD_WMASK);
	end

	////////////////////////////////////////////////////////////////////
	// error responses
	// address parity raises SERR only with both enables
	assign systemErrorAssert = events.addrParity &&
		command[`PCICSR_CMD_SERR] && command[`PCICSR_CMD_PAR];
	// data parity drives PERR only with parity response on
	assign parityErrorAssert = events.dataParity &&
		command[`PCICSR_CMD_PAR];

	////////////////////////////////////////////////////////////////////
	// status flags
	// set terms per clearable bit; set wins over a same-cycle clear
	always_comb
	begin
		stsSet = 16'h0000;
		stsSet[`PCICSR_STS_DPE] = events.addrParity ||
			events.dataParity;
		stsSet[`PCICSR_STS_SSE] = systemErrorAssert;
		stsSet[`PCICSR_STS_MAR] = events.masterAbort;
		stsSet[`PCICSR_STS_TAR] = events.targetAbortRcvd;
		stsSet[`PCICSR_STS_TAS] = events.targetAbortSent;
		stsSet[`PCICSR_STS_MDPE] = events.perrSeenAsMaster &&
			command[`PCICSR_CMD_PAR];
	end

	assign stsClr = cfgWriteData[31:16] & stsWrMask & `PCICSR_STS_CMASK;

	// write one clears, zero keeps; reads never touch the flags
	always_ff @(posedge clk or negedge resetSync2)
	begin
		if (!resetSync2)
			statusFlags <= 16'h0000;
		else
			statusFlags <= ((statusFlags & ~stsClr) | stsSet) &
				`PCICSR_STS_CMASK;
	end

	////////////////////////////////////////////////////////////////////
	// read data and enables
	// fixed status bits are ored in, never stored
	assign cfgReadData = {statusFlags | `PCICSR_STS_FIXED, command};

	// one driver for the whole struct keeps strict tools quiet
	assign enables = '{
		ioSpaceEnable: command[`PCICSR_CMD_IO],
		memorySpaceEnable: command[`PCICSR_CMD_MEM],
		initiatorEnable: command[`PCICSR_CMD_INIT],
		paletteSnoopEnable: command[`PCICSR_CMD_SNOOP],
		parityResponseEnable: command[`PCICSR_CMD_PAR],
		systemErrorDriveEnable: command[`PCICSR_CMD_SERR]
	};

	////////////////////////////////////////////////////////////////////
	// checks
	sequence s_clearWrite(int bitPos);
		hitDword && cfgByteEn[3] && cfgWriteData[16 + bitPos];
	endsequence

	// a master abort, then a clear of its flag one cycle on
	sequence s_abortThenClear;
		events.masterAbort ##1
			s_clearWrite(`PCICSR_STS_MAR) ##0 !events.masterAbort;
	endsequence

	property p_cmdReserved;
		@(posedge clk) disable iff (!resetSync2)
		(cfgReadData[15:9] == 7'h00) && !cfgReadData[7] &&
		(cfgReadData[4:3] == 2'b00);
	endproperty
	a_cmdReserved: assert property (p_cmdReserved)
		else $error("hardwired command bit set");

	property p_fixedStatus;
		@(posedge clk) disable iff (!resetSync2)
		cfgReadData[26:25] == 2'b01 && cfgReadData[20] &&
		cfgReadData[23:21] == 3'b000 && cfgReadData[19:16] == 4'h0;
	endproperty
	a_fixedStatus: assert property (p_fixedStatus)
		else $error("fixed status bits wrong");

	property p_serrGate;
		@(posedge clk) disable iff (!resetSync2)
		systemErrorAssert |-> events.addrParity &&
			enables.systemErrorDriveEnable &&
			enables.parityResponseEnable;
	endproperty
	a_serrGate: assert property (p_serrGate)
		else $error("system error without both enables");

	property p_parityIgnored;
		@(posedge clk) disable iff (!resetSync2)
		!command[`PCICSR_CMD_PAR] |-> !parityErrorAssert;
	endproperty
	a_parityIgnored: assert property (p_parityIgnored)
		else $error("parity response while disabled");

	property p_cmdWrite;
		@(posedge clk) disable iff (!resetSync2)
		hitDword && cfgByteEn[0] |=>
			command[2:0] == $past(cfgWriteData[2:0]);
	endproperty
	a_cmdWrite: assert property (p_cmdWrite)
		else $error("command low bits not written");

	property p_dpeSet;
		@(posedge clk) disable iff (!resetSync2)
		events.addrParity || events.dataParity |=>
			cfgReadData[16 + `PCICSR_STS_DPE];
	endproperty
	a_dpeSet: assert property (p_dpeSet)
		else $error("parity flag not set");

	property p_abortSet;
		@(posedge clk) disable iff (!resetSync2)
		events.masterAbort |=> cfgReadData[16 + `PCICSR_STS_MAR];
	endproperty
	a_abortSet: assert property (p_abortSet)
		else $error("master abort flag not set");

	property p_w1c;
		@(posedge clk) disable iff (!resetSync2)
		s_clearWrite(`PCICSR_STS_TAS) ##0 !events.targetAbortSent |=>
			!statusFlags[`PCICSR_STS_TAS];
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("write one did not clear flag");

	property p_mdpe;
		@(posedge clk) disable iff (!resetSync2)
		$rose(statusFlags[`PCICSR_STS_MDPE]) |->
			$past(events.perrSeenAsMaster) && $past(command[6]);
	endproperty
	a_mdpe: assert property (p_mdpe)
		else $error("master parity flag set without cause");

	// io claim follows its written bit
	property p_ioWrite;
		@(posedge clk) disable iff (!resetSync2)
		hitDword && cfgByteEn[0] |=>
			enables.ioSpaceEnable == $past(cfgWriteData[0]);
	endproperty
	a_ioWrite: assert property (p_ioWrite)
		else $error("io enable not written");

	// memory claim follows its written bit
	property p_memWrite;
		@(posedge clk) disable iff (!resetSync2)
		hitDword && cfgByteEn[0] |=>
			enables.memorySpaceEnable == $past(cfgWriteData[1]);
	endproperty
	a_memWrite: assert property (p_memWrite)
		else $error("memory enable not written");

	// palette snoop follows its written bit
	property p_snoopWrite;
		@(posedge clk) disable iff (!resetSync2)
		hitDword && cfgByteEn[0] |=>
			enables.paletteSnoopEnable == $past(cfgWriteData[5]);
	endproperty
	a_snoopWrite: assert property (p_snoopWrite)
		else $error("snoop enable not written");

	// system error driver enable sits in the upper command lane
	property p_serrWrite;
		@(posedge clk) disable iff (!resetSync2)
		hitDword && cfgByteEn[1] |=>
			enables.systemErrorDriveEnable == $past(cfgWriteData[8]);
	endproperty
	a_serrWrite: assert property (p_serrWrite)
		else $error("system error enable not written");

	// no write, no change: stray addresses leave no trace
	property p_cmdHold;
		@(posedge clk) disable iff (!resetSync2)
		!hitDword |=> command == $past(command);
	endproperty
	a_cmdHold: assert property (p_cmdHold)
		else $error("command changed without a write");

	// only the six writable bits may ever hold a one
	property p_cmdMask;
		@(posedge clk) disable iff (!resetSync2)
		(command & ~`PCICSR_CMD_WMASK) == 16'h0000;
	endproperty
	a_cmdMask: assert property (p_cmdMask)
		else $error("non writable command bit set");

	// back-to-back enable never reads one
	property p_fbbZero;
		@(posedge clk) disable iff (!resetSync2)
		!cfgReadData[9];
	endproperty
	a_fbbZero: assert property (p_fbbZero)
		else $error("back to back enable reads one");

	// stepping control never reads one
	property p_stepZero;
		@(posedge clk) disable iff (!resetSync2)
		!cfgReadData[7];
	endproperty
	a_stepZero: assert property (p_stepZero)
		else $error("stepping bit reads one");

	// data parity with response on must drive the error line
	property p_perrDrive;
		@(posedge clk) disable iff (!resetSync2)
		events.dataParity && command[`PCICSR_CMD_PAR] |->
			parityErrorAssert;
	endproperty
	a_perrDrive: assert property (p_perrDrive)
		else $error("parity response missing");

	// a signalled system error leaves its flag behind
	property p_sseSet;
		@(posedge clk) disable iff (!resetSync2)
		systemErrorAssert |=> statusFlags[`PCICSR_STS_SSE];
	endproperty
	a_sseSet: assert property (p_sseSet)
		else $error("system error flag not set");

	// received target abort sets its flag
	property p_tarSet;
		@(posedge clk) disable iff (!resetSync2)
		events.targetAbortRcvd |=> statusFlags[`PCICSR_STS_TAR];
	endproperty
	a_tarSet: assert property (p_tarSet)
		else $error("received target abort flag not set");

	// signalled target abort sets its flag
	property p_tasSet;
		@(posedge clk) disable iff (!resetSync2)
		events.targetAbortSent |=> statusFlags[`PCICSR_STS_TAS];
	endproperty
	a_tasSet: assert property (p_tasSet)
		else $error("signalled target abort flag not set");

	// stored flags never stray outside the clearable bits
	property p_stsMask;
		@(posedge clk) disable iff (!resetSync2)
		(statusFlags & ~`PCICSR_STS_CMASK) == 16'h0000;
	endproperty
	a_stsMask: assert property (p_stsMask)
		else $error("status flag outside clearable bits");

	// a zero written to a set flag keeps it
	property p_keepFlag;
		@(posedge clk) disable iff (!resetSync2)
		statusFlags[`PCICSR_STS_MAR] && !(hitDword && cfgByteEn[3] &&
			cfgWriteData[16 + `PCICSR_STS_MAR]) |=>
			statusFlags[`PCICSR_STS_MAR];
	endproperty
	a_keepFlag: assert property (p_keepFlag)
		else $error("flag lost without a clear");

	// set, then a clear write on the very next cycle, leaves it clear
	property p_abortClear;
		@(posedge clk) disable iff (!resetSync2)
		s_abortThenClear |=> !statusFlags[`PCICSR_STS_MAR];
	endproperty
	a_abortClear: assert property (p_abortClear)
		else $error("master abort flag not cleared");

endmodule : pcicsr_regs

// ==== shared/pcicsr_regs.svh ====
`ifndef PCICSR_REGS_SVH
`define PCICSR_REGS_SVH
// configuration offsets (byte addresses in config space)
`define PCICSR_OFS_COMMAND 8'h04
`define PCICSR_OFS_STATUS 8'h06
// reset values
`define PCICSR_CMD_RESET 16'h0000
`define PCICSR_STS_RESET 16'h0210
// command writable mask: bits 8,6,5,2,1,0
`define PCICSR_CMD_WMASK 16'h0167
// status clearable mask: bits 15..11 and 8
`define PCICSR_STS_CMASK 16'hF900
// status fixed bits: timing 01b at 10..9, capability list at 4
`define PCICSR_STS_FIXED 16'h0210
// command field positions
`define PCICSR_CMD_IO 0
`define PCICSR_CMD_MEM 1
`define PCICSR_CMD_INIT 2
`define PCICSR_CMD_SNOOP 5
`define PCICSR_CMD_PAR 6
`define PCICSR_CMD_SERR 8
// status field positions
`define PCICSR_STS_MDPE 8
`define PCICSR_STS_TAS 11
`define PCICSR_STS_TAR 12
`define PCICSR_STS_MAR 13
`define PCICSR_STS_SSE 14
`define PCICSR_STS_DPE 15
`endif

// ==== shared/pcicsr_pkg.sv ====
package pcicsr_pkg;
	// error events from the cycle engine, one-cycle pulses
	typedef struct packed {
		logic addrParity;
		logic dataParity;
		logic perrSeenAsMaster;
		logic masterAbort;
		logic targetAbortRcvd;
		logic targetAbortSent;
	} pcicsr_events_t;
	// enables handed to the cycle engine
	typedef struct packed {
		logic ioSpaceEnable;
		logic memorySpaceEnable;
		logic initiatorEnable;
		logic paletteSnoopEnable;
		logic parityResponseEnable;
		logic systemErrorDriveEnable;
	} pcicsr_enables_t;
endpackage : pcicsr_pkg

// ==== sim/pcicsr_engine_model.sv ====
// cycle engine stand-in: turns bench requests into one-cycle error pulses
module pcicsr_engine_model
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [5:0] req, // requested event kinds, struct order
	output pcicsr_pkg::pcicsr_events_t events // pulses seen by the block
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////
	// registered so a pulse never races the block's sampling edge
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			events <= '0;
		else
			events <= pcicsr_pkg::pcicsr_events_t'(req);
	end
endmodule : pcicsr_engine_model

// ==== sim/tb_pcicsr_regs.sv ====
module tb_pcicsr_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic cfgWrite = 1'b0;
	logic [7:0] cfgAddr = 8'h04;
	logic [3:0] cfgByteEn = 4'h0;
	logic [31:0] cfgWriteData = 32'h0;
	logic [31:0] cfgReadData;
	logic [5:0] req = 6'h00;
	pcicsr_pkg::pcicsr_events_t events;
	pcicsr_pkg::pcicsr_enables_t enables;
	logic systemErrorAssert;
	logic parityErrorAssert;
	int num_errors = 0;
	int num_checks = 0;
	// flags per event kind: first six with enables on, last six off
	logic [15:0] flagOf [12] = '{16'hC000, 16'h8000, 16'h0100, 16'h2000,
		16'h1000, 16'h0800, 16'h8000, 16'h8000, 16'h0000, 16'h2000,
		16'h1000, 16'h0800};
	int cmdBit [6] = '{0, 1, 2, 5, 6, 8}; // writable command bits
	logic [15:0] cmdVal;
	////////////////////////////////////////////////////////////////////
	pcicsr_regs u_pcicsr_regs (.clk(clk), .reset_n(reset_n),
		.cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
		.cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
		.events(events), .enables(enables),
		.systemErrorAssert(systemErrorAssert),
		.parityErrorAssert(parityErrorAssert));
	pcicsr_engine_model u_pcicsr_engine_model (.clk(clk),
		.reset_n(reset_n), .req(req), .events(events));
	initial
	begin
		forever #2 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////
	task chk(input string what, input logic [31:0] got,
		input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one config write strobe; returns just after the answering edge
	task wr(input logic [7:0] addr, input logic [3:0] be,
		input logic [31:0] data);
		@(posedge clk);
		cfgWrite <= 1'b1;
		cfgAddr <= addr;
		cfgByteEn <= be;
		cfgWriteData <= data;
		@(posedge clk);
		cfgWrite <= 1'b0;
		#1;
	endtask : wr
	// returns while the event pulse is high at the block
	task fire(input logic [5:0] mask);
		@(posedge clk);
		req <= mask;
		@(posedge clk);
		req <= 6'h00;
		#1;
	endtask : fire
	task end_of_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////
	// watchdog: a hang counts as a mismatch
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_of_test();
	end
	initial
	begin
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("reset", cfgReadData, 32'h0210_0000);
		$display("test defaults done");
		for (int i = 0; i < 6; i++)
		begin
			wr(8'h04, 4'h3, 32'h1 << cmdBit[i]);
			chk("enable", 32'(enables), 32'h20 >> i);
		end
		wr(8'h08, 4'hF, 32'hFFFF_FFFF); // unmapped, must be ignored
		chk("unmapped", cfgReadData, 32'h0210_0100);
		wr(8'h04, 4'h3, 32'hFFFF_FFFF);
		chk("cmd mask", cfgReadData, 32'h0210_0167);
		$display("test command done");
		for (int i = 0; i < 12; i++)
		begin
			cmdVal = (i < 6) ? 16'h0167 : 16'h0000;
			if (i == 6)
				wr(8'h04, 4'h3, 32'h0);
			fire(6'h20 >> (i % 6));
			chk("serr", 32'(systemErrorAssert), 32'(i == 0));
			chk("perr", 32'(parityErrorAssert), 32'(i == 1));
			@(posedge clk);
			#1;
			chk("flag", cfgReadData, {flagOf[i] | 16'h0210, cmdVal});
			wr(8'h04, 4'hC, 32'h0);
			chk("keep", cfgReadData, {flagOf[i] | 16'h0210, cmdVal});
			wr(8'h04, 4'hC, {flagOf[i] | 16'h06FF, 16'h0});
			chk("clear", cfgReadData, {16'h0210, cmdVal});
		end
		$display("test events done");
		wr(8'h04, 4'h3, 32'hFFFF);
		fire(6'h04);
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("rerun reset", cfgReadData, 32'h0210_0000);
		chk("rerun enables", 32'(enables), 32'h0);
		$display("test reset done");
		end_of_test();
	end
endmodule : tb_pcicsr_regs
